// File: hdl/sync_crc_channel.sv
// Purpose: one byte-synchronous channel with CRC generation and checking
// Assumes: serial bits are paced by an internal bit tick of BIT_DIV clocks
// Notes: receive data holding stage is one entry deep

// How it works
// - rx chars pass delay stage; enable applies at load
// - rx CRC done one char time plus one clock per bit after load
// - CRC result latched with each loaded char
// - hunt mode disables and presets rx CRC
// - ready pin drives inverse of control bit, or inverse of rx avail when request bit set
// - carrier pin reported; auto enables gates receiver
// - 8-bit sync sends low sync as fill
// - 6-bit sync sends low six bits only
// - 16-bit sync sends low then high register
// - transmitter never sends 12-bit sync
// - external sync: transmitter uses 6 or 8 bits
// - tx length five to eight, right-justified
// - optional even or odd parity bit appended
// - one bit selects CRC-16 or CCITT polynomial
// - one bit presets CRC to ones or zeros
// - tx CRC preset only by command
// - tx CRC enable sampled at shift load
// - sync fill never enters tx CRC
// - underrun sends CRC unless end flag set
// - end flag set when CRC is loaded
// - disabled transmitter finishes current character
module sync_crc_channel #(
  parameter int BIT_DIV = serial_sync_pkg::DEF_BIT_DIV
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire serial_sync_pkg::bus_req_t i_bus,
  output logic [serial_sync_pkg::DATA_W-1:0] o_rd_data,
  input wire logic i_rxd,
  input wire logic i_carrier_detect_pin,
  input wire logic i_ext_sync_n,
  output logic o_txd,
  output logic o_dtr_req_n
);
  import serial_sync_pkg::*;

  localparam int TW = (BIT_DIV > 2) ? $clog2(BIT_DIV) : 1;

  if (BIT_DIV < 2) begin : g_bad_div
    $error("BIT_DIV must be at least 2");
  end

  // ***************
  // crc helpers
  // ***************
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b,
                                           input logic [15:0] poly);
    logic fb;
    fb = crc[15] ^ b;
    crc_step = {crc[14:0], 1'b0} ^ (fb ? poly : CRC_ZEROS);
  endfunction : crc_step

  function automatic logic [15:0] reverse16(input logic [15:0] v);
    for (int i = 0; i < CRC_W; i++) begin
      reverse16[i] = v[CRC_W-1-i];
    end
  endfunction : reverse16

  // ***************
  // register port
  // ***************
  logic [7:0] cmd_mode_reg, rx_ctrl_reg, mode_reg, tx_ctrl_reg;
  logic [7:0] sync_low_reg, sync_high_reg, misc_reg;
  logic cmd_wr, hunt_cmd;
  logic [1:0] cmd_code;
  logic [15:0] poly, crc_preset;

  assign cmd_wr = i_bus.wr && (i_bus.addr == ADDR_COMMAND);
  assign cmd_code = i_bus.wdata[CMD_LSB +: 2];
  assign hunt_cmd = i_bus.wr && (i_bus.addr == ADDR_RX_CTRL) && i_bus.wdata[RX_HUNT_BIT];
  assign poly = tx_ctrl_reg[TX_POLY_BIT] ? POLY_CRC16 : POLY_CCITT;
  assign crc_preset = misc_reg[MISC_PRESET_BIT] ? CRC_ONES : CRC_ZEROS;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cmd_mode_reg <= REG_RESET;
      rx_ctrl_reg <= REG_RESET;
      mode_reg <= REG_RESET;
      tx_ctrl_reg <= REG_RESET;
      sync_low_reg <= REG_RESET;
      sync_high_reg <= REG_RESET;
      misc_reg <= REG_RESET;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_COMMAND: cmd_mode_reg <= i_bus.wdata & CMD_MODE_MASK;
        ADDR_RX_CTRL: rx_ctrl_reg <= i_bus.wdata & ~RX_HUNT_MASK;
        ADDR_MODE: mode_reg <= i_bus.wdata;
        ADDR_TX_CTRL: tx_ctrl_reg <= i_bus.wdata;
        ADDR_SYNC_LOW: sync_low_reg <= i_bus.wdata;
        ADDR_SYNC_HIGH: sync_high_reg <= i_bus.wdata;
        ADDR_MISC: misc_reg <= i_bus.wdata;
        default: ;
      endcase
    end
  end

  // ***************
  // pin synchronisers and bit tick
  // ***************
  logic rxd_meta, rxd_sync, car_meta, car_sync, esync_meta, esync_sync;
  logic [TW-1:0] tick_cnt_reg;
  logic tick_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      {rxd_meta, rxd_sync} <= 2'h3;
      {car_meta, car_sync} <= 2'h3;
      {esync_meta, esync_sync} <= 2'h3;
    end else begin
      rxd_meta <= i_rxd;
      rxd_sync <= rxd_meta;
      car_meta <= i_carrier_detect_pin;
      car_sync <= car_meta;
      esync_meta <= i_ext_sync_n;
      esync_sync <= esync_meta;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TW'(BIT_DIV - 1));
      tick_cnt_reg <= (tick_cnt_reg == TW'(BIT_DIV - 1)) ? '0 : tick_cnt_reg + 1'b1;
    end
  end

  // ***************
  // receiver
  // ***************
  logic rx_active, hunt_reg, sync_hit, rx_load, rx_read;
  logic [15:0] rx_shift_reg, rx_shifted, rx_crc_reg;
  logic [3:0] rx_cnt_reg, rx_len, delay_len_reg, crc_len_reg, crc_pos_reg;
  logic [7:0] rx_char, delay_reg, crc_src_reg;
  logic crc_on_reg, rx_avail_reg;
  rx_entry_t rx_entry_reg;

  // auto enables: high carrier holds the receiver off
  assign rx_active = rx_ctrl_reg[RX_EN_BIT] & ~(rx_ctrl_reg[RX_AUTO_BIT] & car_sync);
  assign rx_shifted = {rxd_sync, rx_shift_reg[15:1]};
  assign rx_len = {2'h0, rx_ctrl_reg[RX_LEN_LSB +: 2]} + LEN_BASE;
  assign rx_char = rx_shifted[15:8] >> (BYTE_BITS - rx_len);
  assign rx_load = tick_reg && rx_active && !hunt_reg && (rx_cnt_reg + 4'h1 == rx_len);
  assign rx_read = i_bus.rd && (i_bus.addr == ADDR_DATA);

  always_comb begin
    case (mode_reg[MODE_SYNC_LSB +: 2])
      SYNC_EXTERNAL: sync_hit = !esync_sync;
      SYNC_DOUBLE: sync_hit = misc_reg[MISC_SYNC6_BIT]
                              ? (rx_shifted[15:4] == {sync_high_reg, sync_low_reg[7:4]})
                              : (rx_shifted == {sync_high_reg, sync_low_reg});
      default: sync_hit = misc_reg[MISC_SYNC6_BIT]
                          ? (rx_shifted[15:10] == sync_high_reg[7:2])
                          : (rx_shifted[15:8] == sync_high_reg);
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hunt_reg <= 1'b1;
      rx_shift_reg <= CRC_ZEROS;
      rx_cnt_reg <= '0;
    end else if (!rx_active || hunt_cmd) begin
      hunt_reg <= 1'b1;
      rx_cnt_reg <= '0;
    end else if (tick_reg) begin
      rx_shift_reg <= rx_shifted;
      if (hunt_reg) begin
        hunt_reg <= !sync_hit;
        rx_cnt_reg <= '0;
      end else begin
        rx_cnt_reg <= rx_load ? '0 : rx_cnt_reg + 4'h1;
      end
    end
  end

  // delay stage: a loaded char waits one char time, then feeds the checker
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      delay_reg <= REG_RESET;
      delay_len_reg <= '0;
      crc_src_reg <= REG_RESET;
      crc_len_reg <= '0;
      crc_pos_reg <= '0;
      crc_on_reg <= 1'b0;
      rx_crc_reg <= CRC_ZEROS;
    end else if (hunt_reg) begin
      crc_on_reg <= 1'b0;
      rx_crc_reg <= crc_preset;
      crc_pos_reg <= '0;
      crc_len_reg <= '0;
    end else if (rx_load) begin
      delay_reg <= rx_char;
      delay_len_reg <= rx_len;
      crc_src_reg <= delay_reg;
      crc_len_reg <= delay_len_reg;
      crc_pos_reg <= '0;
      crc_on_reg <= rx_ctrl_reg[RX_CRC_EN_BIT];
    end else if (cmd_wr && cmd_code == CMD_RESET_RX_CRC) begin
      rx_crc_reg <= crc_preset;
    end else if (crc_pos_reg < crc_len_reg) begin
      // one bit a clock: done long before the next load latches it
      crc_pos_reg <= crc_pos_reg + 4'h1;
      if (crc_on_reg) begin
        rx_crc_reg <= crc_step(rx_crc_reg, crc_src_reg[crc_pos_reg[2:0]], poly);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_entry_reg <= '0;
      rx_avail_reg <= 1'b0;
    end else if (rx_load) begin
      rx_entry_reg.data <= rx_char;
      rx_entry_reg.crc_err <= (rx_crc_reg != CRC_ZEROS);
      rx_avail_reg <= 1'b1;
    end else if (rx_read) begin
      rx_avail_reg <= 1'b0;
    end
  end

  // ***************
  // transmitter
  // ***************
  tx_kind_t kind_reg, next_kind;
  logic [7:0] tx_buf_reg, tx_mask, tx_masked;
  logic tx_buf_full_reg, eom_reg, tx_inc_reg, next_inc, load_new, cur_inc, par_bit;
  logic [16:0] tx_shift_reg, next_vec, cur_vec;
  logic [4:0] tx_left_reg, next_len, cur_len;
  logic [3:0] tx_len;
  logic [15:0] tx_crc_reg;

  assign load_new = tick_reg && (tx_left_reg == '0);
  assign tx_len = {2'h0, tx_ctrl_reg[TX_LEN_LSB +: 2]} + LEN_BASE;
  assign tx_mask = 8'hFF >> (BYTE_BITS - tx_len);
  assign tx_masked = tx_buf_reg & tx_mask;
  assign par_bit = (^tx_masked) ^ ~mode_reg[MODE_PAR_EVEN_BIT];

  always_comb begin
    next_kind = TX_MARK;
    next_vec = '1;
    next_len = ONE_BIT;
    next_inc = 1'b0;
    if (!tx_ctrl_reg[TX_EN_BIT]) begin
      next_kind = TX_MARK;
    end else if (tx_buf_full_reg) begin
      next_kind = TX_DATA;
      next_vec = 17'(tx_masked) | (17'(par_bit) << tx_len);
      next_len = 5'(tx_len) + (mode_reg[MODE_PAR_EN_BIT] ? ONE_BIT : 5'h00);
      next_inc = tx_ctrl_reg[TX_CRC_EN_BIT];
    end else if (!eom_reg) begin
      next_kind = TX_CRC;
      next_vec = {1'b0, reverse16(tx_crc_reg)};
      next_len = CRC_BITS;
    end else begin
      next_kind = TX_SYNC;
      if (misc_reg[MISC_SYNC6_BIT]) begin
        next_vec = 17'(sync_low_reg[5:0]);
        next_len = SYNC6_BITS;
      end else if (mode_reg[MODE_SYNC_LSB +: 2] == SYNC_DOUBLE) begin
        next_vec = {1'b0, sync_high_reg, sync_low_reg};
        next_len = CRC_BITS;
      end else begin
        next_vec = 17'(sync_low_reg);
        next_len = SYNC8_BITS;
      end
    end
  end

  assign cur_vec = (tx_left_reg == '0) ? next_vec : tx_shift_reg;
  assign cur_len = (tx_left_reg == '0) ? next_len : tx_left_reg;
  assign cur_inc = (tx_left_reg == '0) ? next_inc : tx_inc_reg;

  // a new char is picked only at an empty shifter, so a disable lets it finish
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      kind_reg <= TX_MARK;
      tx_shift_reg <= '1;
      tx_left_reg <= '0;
      tx_inc_reg <= 1'b0;
      o_txd <= 1'b1;
    end else if (tick_reg) begin
      o_txd <= cur_vec[0];
      tx_shift_reg <= {1'b1, cur_vec[16:1]};
      tx_left_reg <= cur_len - ONE_BIT;
      if (load_new) begin
        kind_reg <= next_kind;
        tx_inc_reg <= next_inc;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_crc_reg <= CRC_ZEROS;
    end else if (cmd_wr && cmd_code == CMD_RESET_TX_CRC) begin
      tx_crc_reg <= crc_preset;
    end else if (tick_reg && cur_inc) begin
      tx_crc_reg <= crc_step(tx_crc_reg, cur_vec[0], poly);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_buf_reg <= REG_RESET;
      tx_buf_full_reg <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == ADDR_DATA) begin
      tx_buf_reg <= i_bus.wdata;
      tx_buf_full_reg <= 1'b1;
    end else if (load_new && next_kind == TX_DATA) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // the set wins over a reset command in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      eom_reg <= 1'b1;
    end else if (load_new && next_kind == TX_CRC) begin
      eom_reg <= 1'b1;
    end else if (cmd_wr && cmd_code == CMD_RESET_EOM) begin
      eom_reg <= 1'b0;
    end
  end

  // ***************
  // pins and read data
  // ***************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dtr_req_n <= 1'b1;
    end else begin
      o_dtr_req_n <= misc_reg[MISC_REQ_BIT] ? ~rx_avail_reg : ~tx_ctrl_reg[TX_DTR_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= REG_RESET;
    end else begin
      o_rd_data <= REG_RESET;
      if (i_bus.rd) begin
        case (i_bus.addr)
          ADDR_LINE_STATUS: begin
            o_rd_data[LS_RX_AVAIL_BIT] <= rx_avail_reg;
            o_rd_data[LS_TBE_BIT] <= !tx_buf_full_reg;
            o_rd_data[LS_CARRIER_BIT] <= car_sync;
            o_rd_data[LS_HUNT_BIT] <= hunt_reg;
            o_rd_data[LS_EOM_BIT] <= eom_reg;
          end
          ADDR_ERROR_STATUS: o_rd_data[ES_CRC_ERR_BIT] <= rx_entry_reg.crc_err;
          ADDR_DATA: o_rd_data <= rx_entry_reg.data;
          default: o_rd_data <= REG_RESET;
        endcase
      end
    end
  end

  // ***************
  // assertions
  // ***************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence hunt_hold_s;
    hunt_reg ##1 hunt_reg;
  endsequence

  hunt_crc_a: assert property (hunt_hold_s |-> !crc_on_reg && rx_crc_reg == $past(crc_preset))
    else $error("hunt did not preset and disable the checker");
  rx_latch_a: assert property (rx_load |=> rx_avail_reg &&
      rx_entry_reg.crc_err == ($past(rx_crc_reg) != CRC_ZEROS))
    else $error("crc result not latched with char");
  crc_enable_a: assert property (rx_load && !hunt_reg |=>
      crc_on_reg == $past(rx_ctrl_reg[RX_CRC_EN_BIT]) && crc_src_reg == $past(delay_reg))
    else $error("checker enable not taken at load");
  dtr_pin_a: assert property (!misc_reg[MISC_REQ_BIT] && $stable(misc_reg) |=>
      o_dtr_req_n == !$past(tx_ctrl_reg[TX_DTR_BIT]))
    else $error("ready pin not inverse of control bit");
  auto_enable_a: assert property (rx_ctrl_reg[RX_AUTO_BIT] && car_sync |=> hunt_reg)
    else $error("receiver ran with carrier high");
  eom_set_a: assert property (load_new && next_kind == TX_CRC |=>
      eom_reg && tx_left_reg == CRC_BITS - ONE_BIT)
    else $error("end flag not set on crc load");
  sync_fill_a: assert property (load_new && next_kind == TX_SYNC |=>
      !tx_inc_reg && kind_reg == TX_SYNC)
    else $error("sync fill entered tx crc");
  tx_finish_a: assert property (tick_reg && tx_left_reg != '0 |=>
      tx_left_reg == $past(tx_left_reg) - ONE_BIT)
    else $error("char cut short");
  data_crc_a: assert property (load_new && next_kind == TX_DATA |=> tx_inc_reg ==
      $past(tx_ctrl_reg[TX_CRC_EN_BIT]) && (!tx_buf_full_reg || $past(i_bus.wr)))
    else $error("tx crc enable not sampled at load");
endmodule : sync_crc_channel

// File: pkg/serial_sync_pkg.sv
// Purpose: shared constants and types of the synchronous CRC channel
// Assumes: 8-bit register port, 4-bit index; index 0 and 8 each hold one write and one read register
// Notes: field positions are bit indices inside an 8-bit register
package serial_sync_pkg;
  // ***************
  // register map
  // ***************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CRC_W = 16;
  localparam logic [3:0] ADDR_COMMAND = 4'h0;
  localparam logic [3:0] ADDR_LINE_STATUS = 4'h0;
  localparam logic [3:0] ADDR_ERROR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_RX_CTRL = 4'h3;
  localparam logic [3:0] ADDR_MODE = 4'h4;
  localparam logic [3:0] ADDR_TX_CTRL = 4'h5;
  localparam logic [3:0] ADDR_SYNC_LOW = 4'h6;
  localparam logic [3:0] ADDR_SYNC_HIGH = 4'h7;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_MISC = 4'hA;
  // ***************
  // fields
  // ***************
  localparam int CMD_LSB = 6;
  localparam logic [1:0] CMD_RESET_RX_CRC = 2'h1;
  localparam logic [1:0] CMD_RESET_TX_CRC = 2'h2;
  localparam logic [1:0] CMD_RESET_EOM = 2'h3;
  localparam logic [7:0] CMD_MODE_MASK = 8'h3F;
  localparam int RX_EN_BIT = 0;
  localparam int RX_CRC_EN_BIT = 3;
  localparam int RX_HUNT_BIT = 4;
  localparam int RX_AUTO_BIT = 5;
  localparam int RX_LEN_LSB = 6;
  localparam logic [7:0] RX_HUNT_MASK = 8'h10;
  localparam int MODE_PAR_EN_BIT = 0;
  localparam int MODE_PAR_EVEN_BIT = 1;
  localparam int MODE_SYNC_LSB = 4;
  localparam logic [1:0] SYNC_MONO = 2'h0;
  localparam logic [1:0] SYNC_DOUBLE = 2'h1;
  localparam logic [1:0] SYNC_EXTERNAL = 2'h3;
  localparam int TX_CRC_EN_BIT = 0;
  localparam int TX_POLY_BIT = 2;
  localparam int TX_EN_BIT = 3;
  localparam int TX_LEN_LSB = 5;
  localparam int TX_DTR_BIT = 7;
  localparam int MISC_SYNC6_BIT = 0;
  localparam int MISC_REQ_BIT = 1;
  localparam int MISC_PRESET_BIT = 7;
  localparam int LS_RX_AVAIL_BIT = 0;
  localparam int LS_TBE_BIT = 2;
  localparam int LS_CARRIER_BIT = 3;
  localparam int LS_HUNT_BIT = 4;
  localparam int LS_EOM_BIT = 6;
  localparam int ES_CRC_ERR_BIT = 6;
  // ***************
  // values and counts
  // ***************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] LEN_BASE = 4'h5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] SYNC6_BITS = 5'h06;
  localparam logic [4:0] SYNC8_BITS = 5'h08;
  localparam logic [4:0] CRC_BITS = 5'h10;
  localparam logic [4:0] ONE_BIT = 5'h01;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] CRC_ONES = 16'hFFFF;
  localparam logic [15:0] CRC_ZEROS = 16'h0000;
  localparam int DEF_BIT_DIV = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic crc_err;
  } rx_entry_t;

  typedef enum logic [1:0] {TX_MARK, TX_DATA, TX_SYNC, TX_CRC} tx_kind_t;
endpackage : serial_sync_pkg

// File: tb/serial_line_model.sv
// Purpose: far-side serial line and modem for the sync channel bench
// Assumes: one bit lasts BIT_DIV clocks in both directions
// Notes: an idle receive line toggles every clock, so no stale level lingers
module serial_line_model #(
  parameter int BIT_DIV = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_carrier_detect_pin,
  output logic o_ext_sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen[$];
  logic out_q[$];
  logic last_reg = 1'b1;
  int phase = 0;
  int hold = 0;
  initial begin
    o_rxd = 1'b0;
    o_carrier_detect_pin = 1'b0;
    o_ext_sync_n = 1'b1;
  end
  // ******************
  // line capture and drive
  // ******************
  // relock on every edge of the line, sample mid-bit
  always @(posedge i_ref_clk) begin
    last_reg <= i_txd;
    phase <= (i_txd !== last_reg) ? 1 : (phase + 1) % BIT_DIV;
    if (!i_rst && phase == BIT_DIV / 2) begin
      seen.push_back(i_txd);
    end
  end
  always @(posedge i_ref_clk) begin
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (out_q.size() > 0) begin
      o_rxd <= out_q.pop_front();
      hold <= BIT_DIV - 1;
    end else begin
      o_rxd <= ~o_rxd;
    end
  end
  task automatic queue_bits(input logic b[$]);
    foreach (b[i]) out_q.push_back(b[i]);
  endtask : queue_bits
  task automatic clear_seen();
    seen.delete();
  endtask : clear_seen
  task automatic set_carrier(input logic v);
    o_carrier_detect_pin <= v;
  endtask : set_carrier
endmodule : serial_line_model

// File: tb/sync_crc_channel_tb.sv
// Purpose: self-checking bench of the synchronous CRC channel
// Assumes: BIT_DIV shortened to 4, registers reached over the plain port
// Notes: the transmit stream is judged by searching the captured line bits
module sync_crc_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_sync_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rd_data;
  logic rxd;
  logic carrier;
  logic ext_sync_n;
  logic txd;
  logic dtr_n;
  int failures = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  sync_crc_channel #(.BIT_DIV(DIV)) dut (.i_ref_clk(clk), .i_rst(rst), .i_bus(bus),
    .o_rd_data(rd_data), .i_rxd(rxd), .i_carrier_detect_pin(carrier),
    .i_ext_sync_n(ext_sync_n), .o_txd(txd), .o_dtr_req_n(dtr_n));
  serial_line_model #(.BIT_DIV(DIV)) far (.i_ref_clk(clk), .i_rst(rst), .i_txd(txd),
    .o_rxd(rxd), .o_carrier_detect_pin(carrier), .o_ext_sync_n(ext_sync_n));
  // ******************
  // helpers
  // ******************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read data stand one cycle only, so they are taken mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask : rd
  task automatic poll(input int b, input logic v);
    logic [7:0] d;
    for (int n = 0; n < 100; n++) begin
      rd(ADDR_LINE_STATUS, d);
      if (d[b] === v) return;
    end
    check("line status wait", 16'(d[b]), 16'(v));
  endtask : poll
  task automatic get(output logic [7:0] d, output logic e);
    poll(LS_RX_AVAIL_BIT, 1'b1);
    rd(ADDR_ERROR_STATUS, d);
    e = d[ES_CRC_ERR_BIT];
    rd(ADDR_DATA, d);
  endtask : get
  function automatic void add(ref logic q[$], input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
  endfunction : add
  function automatic logic [15:0] crc_q(input logic [15:0] c, input logic [15:0] p,
                                        input logic b[$]);
    foreach (b[i]) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? p : 16'h0000);
    return c;
  endfunction : crc_q
  function automatic logic found(input logic p[$]);
    for (int s = 0; s + p.size() <= far.seen.size(); s++) begin
      int k;
      k = 0;
      while (k < p.size() && far.seen[s + k] === p[k]) k++;
      if (k == p.size()) return 1'b1;
    end
    return 1'b0;
  endfunction : found
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // ******************
  // scenarios
  // ******************
  task automatic t_reset();
    logic [7:0] d;
    rd(ADDR_LINE_STATUS, d);
    check("line status after reset", 16'(d & 8'h55), 16'h0054);
    rd(4'hF, d);
    check("unmapped read", 16'(d), 16'h0000);
    check("ready pin after reset", 16'(dtr_n), 16'h0001);
  endtask : t_reset
  task automatic t_dtr();
    wr(ADDR_TX_CTRL, 8'h80);
    #1 check("ready pin set", 16'(dtr_n), 16'h0000);
    @(posedge clk);
    wr(ADDR_MISC, 8'h02);
    #1 check("ready pin as request", 16'(dtr_n), 16'h0001);
    @(posedge clk);
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_TX_CTRL, 8'h00);
    #1 check("ready pin clear", 16'(dtr_n), 16'h0001);
    @(posedge clk);
  endtask : t_dtr
  // rows: 8-bit, 6-bit, 16-bit, 12-bit, external 8, external 6
  task automatic t_fill();
    logic [7:0] mode [6] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h30, 8'h30};
    logic [7:0] misc [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
    int len [6] = '{8, 6, 16, 6, 8, 6};
    logic q[$];
    for (int r = 0; r < 6; r++) begin
      wr(ADDR_MODE, mode[r]);
      wr(ADDR_MISC, misc[r]);
      wr(ADDR_SYNC_LOW, 8'hF4);
      wr(ADDR_SYNC_HIGH, 8'h2D);
      wr(ADDR_TX_CTRL, 8'h68);
      repeat (40 * DIV) @(posedge clk);
      far.clear_seen();
      q.delete();
      repeat (3) add(q, 16'h2DF4, len[r]);
      repeat (100 * DIV) @(posedge clk);
      check("sync fill", 16'(found(q)), 16'h0001);
    end
  endtask : t_fill
  task automatic t_frame(input logic p16, input logic ones);
    logic [7:0] ctl;
    logic [7:0] d;
    logic q[$];
    logic m[$];
    logic [15:0] c;
    logic [15:0] r;
    ctl = p16 ? 8'h6D : 8'h69;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MISC, ones ? 8'h80 : 8'h00);
    wr(ADDR_SYNC_LOW, 8'hB4);
    wr(ADDR_TX_CTRL, ctl);
    repeat (16 * DIV) @(posedge clk);
    wr(ADDR_COMMAND, {CMD_RESET_TX_CRC, 6'h00});
    repeat (20 * DIV) @(posedge clk);
    far.clear_seen();
    // let a whole sync char pass the capture before the data goes in
    repeat (16 * DIV) @(posedge clk);
    wr(ADDR_DATA, 8'h3A);
    wr(ADDR_COMMAND, {CMD_RESET_EOM, 6'h00});
    rd(ADDR_LINE_STATUS, d);
    check("end flag cleared", 16'(d[LS_EOM_BIT]), 16'h0000);
    poll(LS_TBE_BIT, 1'b1);
    wr(ADDR_TX_CTRL, ctl & 8'hFE);
    wr(ADDR_DATA, 8'hC5);
    poll(LS_EOM_BIT, 1'b1);
    repeat (30 * DIV) @(posedge clk);
    add(m, 16'h003A, 8);
    c = crc_q(ones ? CRC_ONES : CRC_ZEROS, p16 ? POLY_CRC16 : POLY_CCITT, m);
    r = {<<{c}};
    add(q, 16'h00B4, 8);
    add(q, 16'hC53A, 16);
    add(q, r, 16);
    add(q, 16'h00B4, 8);
    check("crc frame", 16'(found(q)), 16'h0001);
  endtask : t_frame
  // each character meets a disable right after it loads and must still finish
  task automatic t_parity();
    logic [7:0] dat [4] = '{8'hF3, 8'h2A, 8'h55, 8'hA7};
    logic q[$];
    logic p;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_MODE, (r % 2) ? 8'h01 : 8'h03);
      wr(ADDR_SYNC_LOW, 8'h00);
      wr(ADDR_TX_CTRL, 8'h08 | 8'(r << 5));
      repeat (12 * DIV) @(posedge clk);
      far.clear_seen();
      wr(ADDR_DATA, dat[r]);
      poll(LS_TBE_BIT, 1'b1);
      wr(ADDR_TX_CTRL, 8'h00);
      repeat (24 * DIV) @(posedge clk);
      q.delete();
      add(q, 16'(dat[r]), r + 5);
      p = ^(dat[r] & (8'hFF >> (3 - r))) ^ 1'(r % 2);
      q.push_back(p);
      repeat (3) q.push_back(1'b1);
      check("char with parity", 16'(found(q)), 16'h0001);
    end
  endtask : t_parity
  task automatic t_rx(input logic bad);
    logic [7:0] d;
    logic e;
    logic q[$];
    logic m[$];
    logic s[$];
    logic [15:0] r;
    wr(ADDR_TX_CTRL, 8'h04);
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_SYNC_HIGH, 8'h3C);
    wr(ADDR_RX_CTRL, 8'hD1);
    // drop a char left over from an earlier run before the frame arrives
    rd(ADDR_DATA, d);
    rd(ADDR_LINE_STATUS, d);
    check("hunt after enter", 16'(d[LS_HUNT_BIT]), 16'h0001);
    add(m, 16'hC35A, 16);
    r = {<<{crc_q(CRC_ZEROS, POLY_CRC16, m)}};
    add(m, r, 16);
    foreach (m[i]) s.push_back(m[i] ^ (bad && i == 11));
    add(q, 16'h003C, 8);
    foreach (s[i]) q.push_back(s[i]);
    add(q, 16'h2211, 16);
    far.queue_bits(q);
    get(d, e);
    check("rx first char", 16'(d), 16'h005A);
    wr(ADDR_RX_CTRL, 8'hC9);
    get(d, e);
    check("rx second char", 16'(d), bad ? 16'h00CB : 16'h00C3);
    get(d, e);
    get(d, e);
    get(d, e);
    check("result before last", 16'(e), 16'(crc_q(16'h0000, POLY_CRC16, s[0:23]) != 0));
    get(d, e);
    check("result with last", 16'(e), 16'(bad));
    check("rx last char", 16'(d), 16'h0022);
  endtask : t_rx
  task automatic t_carrier();
    logic [7:0] d0;
    logic [7:0] d1;
    logic q[$];
    add(q, 16'h5A3C, 16);
    far.set_carrier(1'b1);
    wr(ADDR_RX_CTRL, 8'hF1);
    rd(ADDR_DATA, d1);
    far.queue_bits(q);
    repeat (30 * DIV) @(posedge clk);
    rd(ADDR_LINE_STATUS, d1);
    check("auto enables blocks", 16'(d1[LS_RX_AVAIL_BIT]), 16'h0000);
    far.set_carrier(1'b0);
    wr(ADDR_RX_CTRL, 8'hF1);
    far.queue_bits(q);
    repeat (30 * DIV) @(posedge clk);
    rd(ADDR_LINE_STATUS, d0);
    check("auto enables passes", 16'(d0[LS_RX_AVAIL_BIT]), 16'h0001);
    check("carrier bit", 16'(d0[LS_CARRIER_BIT] ^ d1[LS_CARRIER_BIT]), 16'h0001);
  endtask : t_carrier
  // ******************
  // run
  // ******************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_dtr();
    t_fill();
    t_frame(1'b1, 1'b1);
    t_frame(1'b0, 1'b0);
    t_parity();
    t_rx(1'b0);
    t_rx(1'b1);
    t_carrier();
    report_and_stop();
  end
  // the whole run needs about 6k cycles; this cuts a hang well after
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule : sync_crc_channel_tb
